// File: lcd_drv_pkg.sv
/*
 * Constants and types shared by the 80-channel dot-matrix driver logic:
 * channel counts, load lengths, drive-level codes and the strap mode type.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package lcd_drv_pkg;

    // channel and load geometry
    localparam int CHANNELS     = 80;
    localparam int DATA_PINS    = 4;
    localparam int SERIAL_LOADS = 80;
    localparam int PAR_LOADS    = 20;
    localparam int COUNT_W      = 7;
    localparam int DRIVE_W      = 2 * CHANNELS;

    localparam logic [COUNT_W-1:0] SERIAL_LAST = 7'h4f;
    localparam logic [COUNT_W-1:0] PAR_LAST    = 7'h13;
    localparam logic [COUNT_W-1:0] COUNT_RST   = 7'h00;

    // drive level per channel: code is {latched bit, polarity}
    localparam logic [1:0] DRV_BIAS_A = 2'h0;
    localparam logic [1:0] DRV_BIAS_B = 2'h1;
    localparam logic [1:0] DRV_GROUND = 2'h2;
    localparam logic [1:0] DRV_SUPPLY = 2'h3;

    // reset values
    localparam logic [CHANNELS-1:0] WORD_RST  = 80'h0;
    localparam logic [DRIVE_W-1:0]  DRIVE_RST = 160'h0;

    // role/input mode picked by the two straps
    typedef enum logic [1:0] {
        MODE_SEG_SERIAL_A,
        MODE_SEG_PAR4,
        MODE_SEG_SERIAL_B,
        MODE_COMMON
    } mode_e;

endpackage

// File: latch_if.sv
/*
 * Carrier between the shift core and the output latch bank.
 * Assumes both ends run on clk_sys.
 */
`timescale 1ns/1ps
interface latch_if;
    import lcd_drv_pkg::*;

    logic [CHANNELS-1:0] word;
    logic                strobe;
    logic                polarity;
    logic [DRIVE_W-1:0]  drive;

    modport core (output word, output strobe, output polarity, input drive);
    modport bank (input word, input strobe, input polarity, output drive);
endinterface

// File: latch_bank.sv
/*
 * Output latch bank: 80 latched display bits and the registered drive-level
 * code of each channel.
 * Assumes strobe is a one-cycle clk_sys pulse and word is stable around it.
 */
`timescale 1ns/1ps
module latch_bank
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    // link to the shift core
    latch_if.bank     lb
);
    import lcd_drv_pkg::*;

    typedef struct packed {
        logic [CHANNELS-1:0] latched;
        logic [DRIVE_W-1:0]  drive;
    } bank_s;

    bank_s st_r;
    bank_s st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (lb.strobe)
        begin
            st_nxt.latched = lb.word;
        end
        for (int i = 0; i < CHANNELS; i++)
        begin
            st_nxt.drive[2*i +: 2] = {st_r.latched[i], lb.polarity};
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_r <= '{latched: WORD_RST, drive: DRIVE_RST};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign lb.drive = st_r.drive;

    latch_copy_a: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        lb.strobe |=> st_r.latched == $past(lb.word))
        else $error("latched bits differ from the word at the strobe");

    latch_hold_a: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        !lb.strobe |=> $stable(st_r.latched))
        else $error("latched bits changed without a strobe");

    drive_first_a: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        ##1 st_r.drive[1:0] == {$past(st_r.latched[0]), $past(lb.polarity)})
        else $error("channel 1 drive level wrong");

    drive_last_a: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        ($past(st_r.latched[CHANNELS-1]) && !$past(lb.polarity))
            |-> st_r.drive[DRIVE_W-1 -: 2] == DRV_GROUND)
        else $error("channel 80 not at ground for a one with low polarity");
endmodule

// File: lcd_row_column_driver_80ch.sv
/*
 * Shift-and-latch logic of an 80-channel segment/common LCD driver.
 * Shift register and chain select run on the falling shift clock edge, chain enable out on the rising edge;
 * the latch clock and polarity are sampled on clk_sys and latch a copy.
 * Assumes data and chain_enable_in meet setup/hold to the falling shift
 * clock edge, and that the latch falls well after the last shift edge.
 */
`timescale 1ns/1ps
module lcd_row_column_driver_80ch
(
    // system clock and reset
    input  wire logic                              clk_sys,
    input  wire logic                              sys_rst,
    // controller clocks
    input  wire logic                              shift_clock,
    input  wire logic                              latch_clock,
    // mode straps
    input  wire logic                              role_strap,
    input  wire logic                              width_strap,
    // display data and polarity
    input  wire logic [lcd_drv_pkg::DATA_PINS-1:0] display_data_inputs,
    input  wire logic                              ac_polarity,
    // cascade chain
    input  wire logic                              chain_enable_in,
    output logic                                   chain_enable_out,
    output logic                                   cascade_data_out,
    // channel drive codes, two bits per channel
    output logic [lcd_drv_pkg::DRIVE_W-1:0]        drive_outputs
);
    import lcd_drv_pkg::*;

    // ---------------- link domain (falling shift clock; enable out on the rising edge) ----------------

    typedef struct packed {
        logic                role_s1;
        logic                role_s2;
        logic                width_s1;
        logic                width_s2;
        logic                sel;
        logic [COUNT_W-1:0]  count;
        logic [CHANNELS-1:0] shift;
        logic                done;
        logic                tog;
        logic                dout;
    } link_s;

    typedef struct packed {
        logic                tog_s1;
        logic                tog_s2;
        logic                tog_s3;
        logic                lat_s1;
        logic                lat_s2;
        logic                lat_s3;
        logic                pol_s1;
        logic                pol_s2;
        logic [CHANNELS-1:0] shadow;
        logic                stb;
    } sys_s;

    link_s               lk_r;
    link_s               lk_nxt;
    sys_s                sy_r;
    sys_s                sy_nxt;
    logic [1:0]          rel_r;
    logic                link_rst;
    logic                eo_r;
    mode_e               mode;
    logic                cs_mode;
    logic                par_mode;
    logic                cap;
    logic [COUNT_W-1:0]  last_cnt;

    // release of sys_rst retimed to the shift clock; assertion stays async
    always_ff @(negedge shift_clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rel_r <= 2'h0;
        end
        else
        begin
            rel_r <= {rel_r[0], 1'b1};
        end
    end

    assign link_rst = ~rel_r[1];

    always_comb
    begin
        case ({lk_r.role_s2, lk_r.width_s2})
            2'b00:   mode = MODE_SEG_SERIAL_A;
            2'b01:   mode = MODE_SEG_PAR4;
            2'b10:   mode = MODE_SEG_SERIAL_B;
            default: mode = MODE_COMMON;
        endcase
    end

    // chip select serves the first serial segment mode and the 4-bit mode
    assign cs_mode  = (mode == MODE_SEG_SERIAL_A) || (mode == MODE_SEG_PAR4);
    assign par_mode = (mode == MODE_SEG_PAR4);
    assign last_cnt = par_mode ? PAR_LAST : SERIAL_LAST;

    always_comb
    begin
        lk_nxt          = lk_r;
        lk_nxt.role_s1  = role_strap;
        lk_nxt.role_s2  = lk_r.role_s1;
        lk_nxt.width_s1 = width_strap;
        lk_nxt.width_s2 = lk_r.width_s1;
        lk_nxt.done     = 1'b0;
        // unselected ignores data until enable in
        cap = !cs_mode || lk_r.sel || chain_enable_in;
        if (cap)
        begin
            lk_nxt.tog = ~lk_r.tog;
            // nibble shift, input n lands on channel n
            if (par_mode)
            begin
                lk_nxt.shift = {display_data_inputs, lk_r.shift[CHANNELS-1:DATA_PINS]};
            end
            // common role shifts the same way
            else
            begin
                lk_nxt.shift = {display_data_inputs[0], lk_r.shift[CHANNELS-1:1]};
            end
            if (cs_mode)
            begin
                // stop after the full load, flag done
                if (lk_r.count == last_cnt)
                begin
                    lk_nxt.sel   = 1'b0;
                    lk_nxt.count = COUNT_RST;
                    lk_nxt.done  = 1'b1;
                end
                // enable in selects, capture this edge
                else
                begin
                    lk_nxt.sel   = 1'b1;
                    lk_nxt.count = COUNT_W'(lk_r.count + 1'b1);
                end
            end
        end
        // cascade output held high under chip select
        lk_nxt.dout = cs_mode ? 1'b1 : lk_nxt.shift[0];
    end

    // shift register moves on the shift clock only
    always_ff @(negedge shift_clock or posedge link_rst)
    begin
        if (link_rst)
        begin
            lk_r <= '{role_s1: 1'b0, role_s2: 1'b0, width_s1: 1'b0, width_s2: 1'b0,
                      sel: 1'b0, count: COUNT_RST, shift: WORD_RST, done: 1'b0,
                      tog: 1'b0, dout: 1'b0};
        end
        else
        begin
            lk_r <= lk_nxt;
        end
    end

    // enable out falls on the rising edge after done clears
    // high from half to one and a half cycles after the last load
    // next device sees it at its following falling edge
    always_ff @(posedge shift_clock or posedge link_rst)
    begin
        if (link_rst)
        begin
            eo_r <= 1'b0;
        end
        else
        begin
            eo_r <= lk_r.done;
        end
    end

    assign chain_enable_out = eo_r;
    assign cascade_data_out = lk_r.dout;

    // ---------------- system domain ----------------

    latch_if lb ();

    // word changes only with tog; two syncs later the word has settled
    always_comb
    begin
        sy_nxt        = sy_r;
        sy_nxt.tog_s1 = lk_r.tog;
        sy_nxt.tog_s2 = sy_r.tog_s1;
        sy_nxt.tog_s3 = sy_r.tog_s2;
        if (sy_r.tog_s2 != sy_r.tog_s3)
        begin
            sy_nxt.shadow = lk_r.shift;
        end
        sy_nxt.lat_s1 = latch_clock;
        sy_nxt.lat_s2 = sy_r.lat_s1;
        sy_nxt.lat_s3 = sy_r.lat_s2;
        sy_nxt.pol_s1 = ac_polarity;
        sy_nxt.pol_s2 = sy_r.pol_s1;
        // latch clock falling edge drives the transfer
        sy_nxt.stb    = sy_r.lat_s3 && !sy_r.lat_s2;
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sy_r <= '{tog_s1: 1'b0, tog_s2: 1'b0, tog_s3: 1'b0, lat_s1: 1'b0,
                      lat_s2: 1'b0, lat_s3: 1'b0, pol_s1: 1'b0, pol_s2: 1'b0,
                      shadow: WORD_RST, stb: 1'b0};
        end
        else
        begin
            sy_r <= sy_nxt;
        end
    end

    assign lb.word     = sy_r.shadow;
    assign lb.strobe   = sy_r.stb;
    assign lb.polarity = sy_r.pol_s2;

    latch_bank u_bank
    (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .lb      (lb.bank)
    );

    assign drive_outputs = lb.drive;

    // ---------------- checks ----------------

    mode_decode_a: assert property (
        @(negedge shift_clock) disable iff (link_rst)
        (lk_r.role_s2 && !lk_r.width_s2) |-> (mode == MODE_SEG_SERIAL_B && !cs_mode))
        else $error("straps high/low must give serial segment without chip select");

    serial_in_a: assert property (
        @(negedge shift_clock) disable iff (link_rst)
        (!cs_mode && !par_mode) ##1 (!cs_mode && !par_mode)
            |-> lk_r.shift[CHANNELS-1] == $past(display_data_inputs[0]))
        else $error("serial bit not taken from input one");

    par_in_a: assert property (
        @(negedge shift_clock) disable iff (link_rst)
        (par_mode && cap) |=> lk_r.shift[CHANNELS-1 -: DATA_PINS] == $past(display_data_inputs))
        else $error("nibble not placed on the top four stages");

    free_shift_a: assert property (
        @(negedge shift_clock) disable iff (link_rst)
        (!cs_mode && !par_mode)
            |=> lk_r.shift[CHANNELS-2:0] == $past(lk_r.shift[CHANNELS-1:1]))
        else $error("shift register did not advance in a free-running mode");

    idle_hold_a: assert property (
        @(negedge shift_clock) disable iff (link_rst)
        (cs_mode && !lk_r.sel && !chain_enable_in) |=> $stable(lk_r.shift))
        else $error("unselected device took data");

    select_a: assert property (
        @(negedge shift_clock) disable iff (link_rst)
        (cs_mode && !lk_r.sel && chain_enable_in && lk_r.count == COUNT_RST)
            |=> lk_r.sel && lk_r.count == 7'h01)
        else $error("enable in did not select the device");

    load_end_a: assert property (
        @(negedge shift_clock) disable iff (link_rst)
        (cs_mode && cap && lk_r.count == last_cnt) |=> (lk_r.done && !lk_r.sel))
        else $error("load did not end after the full count");

    eo_pulse_a: assert property (
        @(posedge shift_clock) disable iff (link_rst)
        $rose(eo_r) |=> !eo_r)
        else $error("enable out stayed high past one and a half cycles");

    do_high_a: assert property (
        @(negedge shift_clock) disable iff (link_rst)
        cs_mode ##1 cs_mode |-> cascade_data_out)
        else $error("cascade output not high under chip select");

    latch_event_a: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        (sy_r.lat_s3 && !sy_r.lat_s2) |=> (lb.strobe ##1 !lb.strobe))
        else $error("latch fall did not give a single strobe");
endmodule

// File: lcd_ctrl_model.sv
/*
 * Behavioural model of the LCD controller that feeds the driver: shift
 * clock, latch clock, display data and the chain start enable.
 * Assumes the bench calls its tasks one at a time, never overlapping.
 */
`timescale 1ns/1ps
module lcd_ctrl_model
(
    // controller clocks
    output logic                              shift_clock,
    output logic                              latch_clock,
    // data and chain start
    output logic [lcd_drv_pkg::DATA_PINS-1:0] display_data_inputs,
    output logic                              chain_enable_in
);
    import lcd_drv_pkg::*;

    logic [DATA_PINS-1:0] mask;
    int                   stretch;

    // clock stands high between frames
    initial
    begin
        shift_clock         = 1'b1;
        latch_clock         = 1'b0;
        display_data_inputs = 4'h0;
        chain_enable_in     = 1'b0;
        mask                = 4'hf;
        stretch             = 0;
    end

    // slow pace: low 140, high 240, period 380 ns
    task automatic set_pace(input logic slow);
        stretch = slow ? 100 : 0;
    endtask

    task automatic set_width(input logic par);
        mask = par ? 4'hf : 4'h1;
    endtask

    task automatic shift(input logic [DATA_PINS-1:0] d, input logic e);
        display_data_inputs = d & mask;
        chain_enable_in     = e;
        #(20 + stretch) shift_clock = 1'b0;
        // past hold the unmasked lines no longer show the old value
        #10 display_data_inputs = ~d & mask;
        chain_enable_in = ~e;
        #(30 + stretch) shift_clock = 1'b1;
        #(20 + stretch);
    endtask

    task automatic latch();
        latch_clock = 1'b1;
        #160 latch_clock = 1'b0;
    endtask
endmodule

// File: lcd_row_column_driver_80ch_bench.sv
/*
 * Self-checking bench for the 80-channel driver: loads every strap mode
 * through the controller model, then latches and compares drive codes.
 * Assumes the design package and the controller model are compiled first.
 */
`timescale 1ns/1ps
module lcd_row_column_driver_80ch_bench;
    import lcd_drv_pkg::*;

    logic                 clk_sys;
    logic                 sys_rst;
    logic                 role_strap;
    logic                 width_strap;
    logic                 ac_polarity;
    logic                 shift_clock;
    logic                 latch_clock;
    logic [DATA_PINS-1:0] display_data_inputs;
    logic                 chain_enable_in;
    logic                 chain_enable_out;
    logic                 cascade_data_out;
    logic [DRIVE_W-1:0]   drive_outputs;
    logic [CHANNELS-1:0]  w;
    logic [CHANNELS-1:0]  pats [4];
    logic                 cs;
    logic                 par;
    int                   fails;
    int                   check_count;

    lcd_ctrl_model ctrl
    (
        .shift_clock         (shift_clock),
        .latch_clock         (latch_clock),
        .display_data_inputs (display_data_inputs),
        .chain_enable_in     (chain_enable_in)
    );

    lcd_row_column_driver_80ch uut
    (
        .clk_sys             (clk_sys),
        .sys_rst             (sys_rst),
        .shift_clock         (shift_clock),
        .latch_clock         (latch_clock),
        .role_strap          (role_strap),
        .width_strap         (width_strap),
        .display_data_inputs (display_data_inputs),
        .ac_polarity         (ac_polarity),
        .chain_enable_in     (chain_enable_in),
        .chain_enable_out    (chain_enable_out),
        .cascade_data_out    (cascade_data_out),
        .drive_outputs       (drive_outputs)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic wrap_up();
        if (fails == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [DRIVE_W-1:0] got, input logic [DRIVE_W-1:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [DRIVE_W-1:0] exp_drive(input logic pol);
        logic [DRIVE_W-1:0] r;
        for (int c = 0; c < CHANNELS; c++)
            r[2*c +: 2] = w[c] ? (pol ? DRV_SUPPLY : DRV_GROUND)
                               : (pol ? DRV_BIAS_B : DRV_BIAS_A);
        return r;
    endfunction

    // straps settle over a few link edges; enable is low at every falling edge meanwhile
    task automatic set_mode(input logic r, input logic wd);
        @(posedge clk_sys);
        #1 role_strap = r;
        width_strap = wd;
        ctrl.set_width(wd && !r);
        ctrl.set_pace(!r && !wd);
        repeat (4) ctrl.shift(4'h0, 1'b0);
    endtask

    task automatic load();
        int n;
        n = par ? PAR_LOADS : SERIAL_LOADS;
        for (int j = 0; j < n; j++)
        begin
            if (par)
                ctrl.shift(w[4*j +: 4], cs && j == 0);
            else
                ctrl.shift({3'h0, w[j]}, cs && j == 0);
            if (cs && j >= n - 2)
                chk(DRIVE_W'(chain_enable_out), DRIVE_W'(j == n - 1));
        end
    endtask

    task automatic latch_chk();
        ctrl.latch();
        repeat (10) @(posedge clk_sys);
        chk(drive_outputs, exp_drive(1'b0));
        #1 ac_polarity = 1'b1;
        repeat (8) @(posedge clk_sys);
        chk(drive_outputs, exp_drive(1'b1));
        #1 ac_polarity = 1'b0;
        repeat (8) @(posedge clk_sys);
    endtask

    initial
    begin
        #200000;
        fails++;
        wrap_up();
    end

    initial
    begin
        sys_rst     = 1'b1;
        role_strap  = 1'b0;
        width_strap = 1'b0;
        ac_polarity = 1'b0;
        fails       = 0;
        check_count = 0;
        pats[0]     = 80'h0123456789abcdef1357;
        pats[1]     = 80'hf0e1d2c3b4a596877869;
        pats[2]     = 80'h5a5a3c3c0ff0c33c9668;
        pats[3]     = 80'h8000000000000000_0001;
        // link release and strap sync come from the set_mode shifts
        repeat (6) @(posedge clk_sys);
        #1 sys_rst = 1'b0;
        for (int m = 0; m < 4; m++)
        begin
            w = pats[m];
            cs = (m < 2);
            par = (m == 1);
            set_mode(m[1], m[0]);
            load();
            if (cs)
            begin
                ctrl.shift(4'h0, 1'b0);
                chk(DRIVE_W'(chain_enable_out), DRIVE_W'(1'b0));
                chk(DRIVE_W'(cascade_data_out), DRIVE_W'(1'b1));
            end
            else
                chk(DRIVE_W'(cascade_data_out), DRIVE_W'(w[0]));
            latch_chk();
            if (cs)
            begin
                // unselected device must ignore this data
                repeat (4) ctrl.shift(4'ha, 1'b0);
                latch_chk();
            end
        end
        wrap_up();
    end
endmodule
